/* logic/smrsc_top.sv */
// System mutex, boot remap and sticky security control
// Contract
// - 32-bit owner status is read-only; changed by write-only set and reset ports.
// - Each 2-bit owner field: 0 free, 1 reserved, 2 app cpu, 3 radio cpu.
// - Fields in pairs from bit 0 to bit 27; bits 28-31 reserved.
// - Owner status is not retained over sleep; it comes back cleared.
// - A 3-bit remap field selects what appears at address zero.
// - Retained flash base register feeds the cache miss fetch address while remap selects eflash (code 1); otherwise zero.
// - Security bits are set-once; only power-on reset clears them.
// - Debug-kill bit disconnects that processor's serial-wire debug signals.
// - App code lock rejects write and erase on sectors 5 to 12.
// - App key lock rejects read and erase at 0x800-0xbff of sector 2.
// - Signature key lock rejects write and erase at 0xc00-0xfff of sector 2.
// - Config script lock rejects write and erase on sector 1.
// - Non-sticky debug-allow bit resets off; debug-kill overrides it.
// - Failed image authentication with secure boot issues a hardware reset.
// - No image authentication when booting from external quad-SPI flash.
// - Eight app key and eight auth key slots, revocable active selections.
// - A 64-bit unique identification word is readable.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module smrsc_top
    import smrsc_pkg::*;
#(
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef  // Arbitrary value
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic powerOnResetn,
    input wire logic sleepEntry,
    // App cpu register port
    input wire logic [smrsc_pkg::ADDR_W-1:0] appAddr,
    input wire logic [31:0] appWdata,
    input wire logic appWr,
    input wire logic appRd,
    output logic [31:0] appRdata,
    // Radio cpu register port
    input wire logic [smrsc_pkg::ADDR_W-1:0] radioAddr,
    input wire logic [31:0] radioWdata,
    input wire logic radioWr,
    input wire logic radioRd,
    output logic [31:0] radioRdata,
    // Debug port gating
    input wire logic appSwdIn,
    input wire logic radioSwdIn,
    output logic appSwdOut,
    output logic radioSwdOut,
    // Flash operation check
    input wire logic flashReq,
    input wire smrsc_pkg::smrsc_flash_op_t flashOp,
    input wire logic [smrsc_pkg::SECT_W-1:0] flashSector,
    input wire logic [31:0] flashAddr,
    output logic flashGrant,
    output logic flashReject,
    // Boot authentication and cache
    input wire logic authDone,
    input wire logic authMatch,
    input wire logic bootFromQspi,
    output logic hwResetReq,
    output logic [2:0] remapSel,
    output logic [31:0] cacheMissBase
);
    import smrsc_pkg::*;

    logic [31:0] owner_r, owner_nxt;
    logic [2:0] remap_r, remap_nxt;
    logic dbgAllow_r, dbgAllow_nxt;
    logic [SEC_W-1:0] sec_r, sec_nxt;
    logic [31:0] base_r, base_nxt;
    logic [2:0] appKey_r, appKey_nxt, authKey_r, authKey_nxt;
    logic hwRst_r, hwRst_nxt;
    logic flashGrant_r, flashGrant_nxt, flashReject_r, flashReject_nxt;
    logic [31:0] appRdata_r, appRdata_nxt, radioRdata_r, radioRdata_nxt;
    logic appDbgS1_r, appDbgS2_r, radioDbgS1_r, radioDbgS2_r;

    function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a, input logic [31:0] own,
        input logic [2:0] rm, input logic da, input logic [SEC_W-1:0] s, input logic [31:0] b,
        input logic [2:0] ak, input logic [2:0] uk);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            OFS_OWNER_STATUS: d = own;
            OFS_SYS_CTRL: d = {28'h0000000, da, rm};
            OFS_SECURITY: d = {25'h0000000, s};
            OFS_EFLASH_BASE: d = b;
            OFS_UID_LO: d = UNIQUE_ID[31:0];
            OFS_UID_HI: d = UNIQUE_ID[63:32];
            OFS_KEY_SEL: d = {25'h0000000, uk, 1'b0, ak};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : readMux

    // Apply set/reset requests of one cpu to the owner image
    function automatic logic [31:0] applyOwn(input logic [31:0] cur, input logic [31:0] mask,
        input logic set, input logic clr, input logic [1:0] code);
        logic [31:0] r;
        r = cur;
        for (int i = 0; i < NUM_FIELDS; i++) begin
            if (mask[2*i] || mask[2*i+1]) begin
                if (set && cur[2*i+:2] == OWN_FREE) begin
                    r[2*i+:2] = code;
                end else if (clr && cur[2*i+:2] == code) begin
                    r[2*i+:2] = OWN_FREE;
                end
            end
        end
        return r;
    endfunction : applyOwn

    always_comb begin
        logic [31:0] t;
        t = owner_r;
        // App cpu first: on a same-cycle claim it wins
        t = applyOwn(t, appWdata, appWr && appAddr == OFS_OWNER_SET,
            appWr && appAddr == OFS_OWNER_RESET, OWN_APP);
        t = applyOwn(t, radioWdata, radioWr && radioAddr == OFS_OWNER_SET,
            radioWr && radioAddr == OFS_OWNER_RESET, OWN_RADIO);
        owner_nxt = {4'h0, t[27:0]};
        if (sleepEntry) begin
            owner_nxt = OWNER_RESET;
        end
    end

    always_comb begin
        remap_nxt = remap_r;
        dbgAllow_nxt = dbgAllow_r;
        sec_nxt = sec_r;
        base_nxt = base_r;
        appKey_nxt = appKey_r;
        authKey_nxt = authKey_r;
        if (appWr) begin
            unique case (appAddr)
                OFS_SYS_CTRL: begin
                    if (appWdata[2:0] != REMAP_RSVD) begin
                        remap_nxt = appWdata[2:0];
                    end
                    dbgAllow_nxt = appWdata[DBG_ALLOW_BIT];
                end
                OFS_SECURITY: sec_nxt = sec_r | appWdata[SEC_W-1:0];
                OFS_EFLASH_BASE: base_nxt = appWdata;
                // Revocation only moves forward to a newer key
                OFS_KEY_SEL: begin
                    if (appWdata[2:0] > appKey_r) begin
                        appKey_nxt = appWdata[2:0];
                    end
                    if (appWdata[6:4] > authKey_r) begin
                        authKey_nxt = appWdata[6:4];
                    end
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        logic inKeys, inSig;
        inKeys = flashSector == SECT_KEYS && flashAddr >= APP_KEY_LO && flashAddr <= APP_KEY_HI;
        inSig = flashSector == SECT_KEYS && flashAddr >= SIG_KEY_LO && flashAddr <= SIG_KEY_HI;
        flashReject_nxt = 1'b0;
        if (flashReq) begin
            if (flashOp != FLASH_READ && sec_r[SEC_APP_CODE] && flashSector >= SECT_APP_LO
                && flashSector <= SECT_APP_HI) begin
                flashReject_nxt = 1'b1;
            end
            if (flashOp != FLASH_WRITE && sec_r[SEC_APP_KEY] && inKeys) begin
                flashReject_nxt = 1'b1;
            end
            if (flashOp != FLASH_READ && sec_r[SEC_SIG_KEY] && inSig) begin
                flashReject_nxt = 1'b1;
            end
            if (flashOp != FLASH_READ && sec_r[SEC_CFG_SCRIPT] && flashSector == SECT_CFG) begin
                flashReject_nxt = 1'b1;
            end
        end
        flashGrant_nxt = flashReq && !flashReject_nxt;
        // Secure boot skipped for quad-SPI boot
        hwRst_nxt = authDone && sec_r[SEC_SECURE_BOOT] && !bootFromQspi && !authMatch;
        appRdata_nxt = appRd ? readMux(appAddr, owner_r, remap_r, dbgAllow_r, sec_r, base_r,
            appKey_r, authKey_r) : 32'h0000_0000;
        radioRdata_nxt = radioRd ? readMux(radioAddr, owner_r, remap_r, dbgAllow_r, sec_r, base_r,
            appKey_r, authKey_r) : 32'h0000_0000;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            owner_r <= OWNER_RESET;
            remap_r <= REMAP_RESET;
            dbgAllow_r <= 1'b0;
            appKey_r <= 3'h0;
            authKey_r <= 3'h0;
            hwRst_r <= 1'b0;
            flashGrant_r <= 1'b0;
            flashReject_r <= 1'b0;
            appRdata_r <= 32'h0000_0000;
            radioRdata_r <= 32'h0000_0000;
            appDbgS1_r <= 1'b0;
            appDbgS2_r <= 1'b0;
            radioDbgS1_r <= 1'b0;
            radioDbgS2_r <= 1'b0;
        end else begin
            owner_r <= owner_nxt;
            remap_r <= remap_nxt;
            dbgAllow_r <= dbgAllow_nxt;
            appKey_r <= appKey_nxt;
            authKey_r <= authKey_nxt;
            hwRst_r <= hwRst_nxt;
            flashGrant_r <= flashGrant_nxt;
            flashReject_r <= flashReject_nxt;
            appRdata_r <= appRdata_nxt;
            radioRdata_r <= radioRdata_nxt;
            appDbgS1_r <= appSwdIn;
            appDbgS2_r <= appDbgS1_r;
            radioDbgS1_r <= radioSwdIn;
            radioDbgS2_r <= radioDbgS1_r;
        end
    end

    // Sticky bits and the retained base survive soft reset; only power-on clears them
    always_ff @(posedge core_clk) begin
        if (!powerOnResetn) begin
            sec_r <= '0;
            base_r <= 32'h0000_0000;
        end else begin
            sec_r <= sec_nxt;
            base_r <= base_nxt;
        end
    end

    assign appSwdOut = appDbgS2_r && dbgAllow_r && !sec_r[SEC_APP_DBG_KILL];
    assign radioSwdOut = radioDbgS2_r && dbgAllow_r && !sec_r[SEC_RADIO_DBG_KILL];
    assign appRdata = appRdata_r;
    assign radioRdata = radioRdata_r;
    assign flashGrant = flashGrant_r;
    assign flashReject = flashReject_r;
    assign hwResetReq = hwRst_r;
    assign remapSel = remap_r;
    assign cacheMissBase = (remap_r == REMAP_EFLASH) ? base_r : 32'h0000_0000;
endmodule : smrsc_top
`default_nettype wire

/* logic/smrsc_pkg.sv */
// Package for the system mutex, remap and security control block
package smrsc_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_OWNER_STATUS = 8'h00;
    localparam logic [7:0] OFS_OWNER_SET = 8'h04;
    localparam logic [7:0] OFS_OWNER_RESET = 8'h08;
    localparam logic [7:0] OFS_SYS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_SECURITY = 8'h10;
    localparam logic [7:0] OFS_EFLASH_BASE = 8'h14;
    localparam logic [7:0] OFS_UID_LO = 8'h18;
    localparam logic [7:0] OFS_UID_HI = 8'h1c;
    localparam logic [7:0] OFS_KEY_SEL = 8'h20;
    localparam logic [7:0] OFS_AUTH = 8'h24;
    // Owner codes
    localparam logic [1:0] OWN_FREE = 2'h0;
    localparam logic [1:0] OWN_RSVD = 2'h1;
    localparam logic [1:0] OWN_APP = 2'h2;
    localparam logic [1:0] OWN_RADIO = 2'h3;
    localparam int NUM_FIELDS = 14;
    localparam logic [31:0] OWNER_RESET = 32'h0000_0000;
    // System control fields
    localparam int REMAP_LSB = 0;
    localparam int DBG_ALLOW_BIT = 3;
    localparam logic [2:0] REMAP_RESET = 3'h0;
    localparam logic [2:0] REMAP_EFLASH = 3'h1;
    localparam logic [2:0] REMAP_QSPI_C = 3'h2;
    localparam logic [2:0] REMAP_QSPI_U = 3'h6;
    localparam logic [2:0] REMAP_RSVD = 3'h7;
    // Security bits
    localparam int SEC_APP_DBG_KILL = 0;
    localparam int SEC_RADIO_DBG_KILL = 1;
    localparam int SEC_APP_CODE = 2;
    localparam int SEC_APP_KEY = 3;
    localparam int SEC_SIG_KEY = 4;
    localparam int SEC_CFG_SCRIPT = 5;
    localparam int SEC_SECURE_BOOT = 6;
    localparam int SEC_W = 7;
    // Flash protection geometry
    localparam int SECT_W = 4;
    localparam logic [3:0] SECT_CFG = 4'h1;
    localparam logic [3:0] SECT_KEYS = 4'h2;
    localparam logic [3:0] SECT_APP_LO = 4'h5;
    localparam logic [3:0] SECT_APP_HI = 4'hc;
    localparam logic [31:0] APP_KEY_LO = 32'h0000_0800;
    localparam logic [31:0] APP_KEY_HI = 32'h0000_0bff;
    localparam logic [31:0] SIG_KEY_LO = 32'h0000_0c00;
    localparam logic [31:0] SIG_KEY_HI = 32'h0000_0fff;
    localparam int KEY_SLOTS = 8;
    typedef enum logic [1:0] {FLASH_READ, FLASH_WRITE, FLASH_ERASE} smrsc_flash_op_t;
endpackage : smrsc_pkg

/* bench/smrsc_checker.sv */
// Port assertions for the mutex, remap and security block
`timescale 1ns/1ps
`default_nettype none
module smrsc_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sleepEntry,
    // Register ports
    input wire logic [smrsc_pkg::ADDR_W-1:0] appAddr,
    input wire logic appWr,
    input wire logic appRd,
    input wire logic [31:0] appRdata,
    input wire logic radioWr,
    // Debug, flash and boot
    input wire logic appSwdIn,
    input wire logic appSwdOut,
    input wire logic flashReq,
    input wire smrsc_pkg::smrsc_flash_op_t flashOp,
    input wire logic [smrsc_pkg::SECT_W-1:0] flashSector,
    input wire logic flashGrant,
    input wire logic flashReject,
    input wire logic authDone,
    input wire logic authMatch,
    input wire logic bootFromQspi,
    input wire logic hwResetReq,
    input wire logic [2:0] remapSel,
    input wire logic [31:0] cacheMissBase
);
    import smrsc_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // No writes around the sleep so a late claim cannot mask the clear
    sequence sleepGo;
        sleepEntry && !appWr && !radioWr;
    endsequence
    sequence statusRead;
        appRd && appAddr == OFS_OWNER_STATUS && !appWr && !radioWr;
    endsequence
    rd_slot_a: assert property (!$past(appRd) |-> appRdata == 32'h0) else $error("read data outside slot");
    sleep_clear_a: assert property (sleepGo ##1 (!appWr && !radioWr) ##1 statusRead |=> appRdata == 32'h0)
        else $error("owner status kept over sleep");
    rsvd_bits_a: assert property ($past(appRd && appAddr == OFS_OWNER_STATUS) |-> appRdata[31:28] == 4'h0)
        else $error("reserved owner bits set");
    boot_reset_a: assert property (hwResetReq |-> $past(authDone && !authMatch && !bootFromQspi))
        else $error("reset request without failed check");
    flash_cause_a: assert property ((flashGrant || flashReject) |-> $past(flashReq))
        else $error("flash answer without request");
    flash_one_a: assert property (flashReq |=> flashGrant ^ flashReject) else $error("flash answer not single");
    read_open_a: assert property (flashReq && flashOp == FLASH_READ && flashSector != SECT_KEYS
        |=> flashGrant) else $error("plain read refused");
    remap_rsvd_a: assert property (remapSel != REMAP_RSVD) else $error("reserved remap code");
    base_gate_a: assert property (remapSel != REMAP_EFLASH |-> cacheMissBase == 32'h0) else $error("base leaks");
    swd_gate_a: assert property (appSwdOut |-> $past(appSwdIn, 2)) else $error("debug out without pin");
endmodule : smrsc_checker
bind smrsc_top smrsc_checker smrsc_checker_i (.*);
`default_nettype wire

/* bench/smrsc_cpu_model.sv */
// Bus master model of one on-chip processor
`timescale 1ns/1ps
`default_nettype none
module smrsc_cpu_model (
    // Register port
    input wire logic clk,
    output logic [smrsc_pkg::ADDR_W-1:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [31:0] rdata
);
    import smrsc_pkg::*;
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic claim(input logic [31:0] m, output logic [31:0] s);
        wr_reg(OFS_OWNER_SET, m);
        rd_reg(OFS_OWNER_STATUS, s);
    endtask : claim
endmodule : smrsc_cpu_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the mutex, remap and security block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import smrsc_pkg::*;
    localparam logic [63:0] UID = 64'h5a5a_0f0f_3c3c_9696; // Arbitrary value
    logic core_clk = 1'b0, resetn = 1'b0, powerOnResetn = 1'b0, sleepEntry = 1'b0;
    logic appSwdIn = 1'b0, radioSwdIn = 1'b0, appSwdOut, radioSwdOut;
    logic [7:0] appAddr, radioAddr;
    logic [31:0] appWdata, appRdata, radioWdata, radioRdata, cacheMissBase, flashAddr = '0;
    logic appWr, appRd, radioWr, radioRd, flashGrant, flashReject, hwResetReq;
    logic flashReq = 1'b0, authDone = 1'b0, authMatch = 1'b0, bootFromQspi = 1'b0;
    logic [3:0] flashSector = '0;
    logic [2:0] remapSel;
    smrsc_flash_op_t flashOp = FLASH_READ;
    int n_fail = 0, n_checks = 0, cycles = 0;
    smrsc_top #(.UNIQUE_ID(UID)) smrsc_top_i (.*);
    smrsc_cpu_model appCpu (.clk(core_clk), .addr(appAddr), .wdata(appWdata), .wr(appWr), .rd(appRd),
        .rdata(appRdata));
    smrsc_cpu_model radioCpu (.clk(core_clk), .addr(radioAddr), .wdata(radioWdata), .wr(radioWr),
        .rd(radioRd), .rdata(radioRdata));
    always #10 core_clk = ~core_clk;
    task automatic final_report();
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rst(input logic por);
        @(posedge core_clk);
        resetn <= por;
        powerOnResetn <= ~por;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        powerOnResetn <= 1'b1;
    endtask : rst
    task automatic fl(input smrsc_flash_op_t op, input logic [3:0] sec, input logic [31:0] a, input logic rej);
        @(posedge core_clk);
        flashReq <= 1'b1;
        flashOp <= op;
        flashSector <= sec;
        flashAddr <= a;
        @(posedge core_clk);
        flashReq <= 1'b0;
        #1 chk("flash", 32'({flashGrant, flashReject}), 32'({~rej, rej}));
    endtask : fl
    task automatic t_mutex();
        logic [31:0] s;
        appCpu.claim(32'h3, s);
        chk("claim app", s, 32'h2);
        radioCpu.claim(32'h1, s);
        chk("claim taken", s, 32'h2);
        radioCpu.claim(32'hc, s);
        chk("claim radio", s, 32'he);
        radioCpu.wr_reg(OFS_OWNER_RESET, 32'h3);
        appCpu.wr_reg(OFS_OWNER_STATUS, 32'hffff_ffff);
        appCpu.claim(32'hf000_0000, s);
        chk("foreign release", s, 32'he);
        appCpu.wr_reg(OFS_OWNER_RESET, 32'h3);
        fork
            appCpu.wr_reg(OFS_OWNER_SET, 32'h3000);
            radioCpu.wr_reg(OFS_OWNER_SET, 32'h3000);
        join
        appCpu.rd_reg(OFS_OWNER_STATUS, s);
        chk("race", s, 32'h200c);
        @(posedge core_clk);
        sleepEntry <= 1'b1;
        @(posedge core_clk);
        sleepEntry <= 1'b0;
        appCpu.rd_reg(OFS_OWNER_STATUS, s);
        chk("sleep", s, 32'h0);
    endtask : t_mutex
    task automatic t_regs();
        logic [31:0] s;
        for (int c = 0; c < 7; c++) begin
            appCpu.wr_reg(OFS_SYS_CTRL, 32'(c));
            appCpu.rd_reg(OFS_SYS_CTRL, s);
            chk("remap", s, 32'(c));
        end
        appCpu.wr_reg(OFS_SYS_CTRL, 32'h7);
        #1 chk("remap rsvd", 32'(remapSel), 32'h6);
        appCpu.wr_reg(OFS_EFLASH_BASE, 32'h0001_2000);
        #1 chk("base off", cacheMissBase, 32'h0);
        appCpu.wr_reg(OFS_SYS_CTRL, 32'h1);
        #1 chk("base on", cacheMissBase, 32'h0001_2000);
        appCpu.wr_reg(OFS_KEY_SEL, 32'h23);
        appCpu.wr_reg(OFS_KEY_SEL, 32'h11);
        appCpu.rd_reg(OFS_KEY_SEL, s);
        chk("key select", s, 32'h23);
        appCpu.rd_reg(OFS_UID_LO, s);
        chk("uid lo", s, UID[31:0]);
        radioCpu.rd_reg(OFS_UID_HI, s);
        chk("uid hi", s, UID[63:32]);
        appCpu.rd_reg(OFS_AUTH, s);
        chk("unmapped", s, 32'h0);
    endtask : t_regs
    task automatic t_secure();
        logic [31:0] s;
        fl(FLASH_WRITE, 4'h1, 32'h0, 1'b0);
        appCpu.wr_reg(OFS_SECURITY, 32'h3c);
        fl(FLASH_WRITE, 4'h5, 32'h0, 1'b1);
        fl(FLASH_ERASE, 4'hc, 32'h0, 1'b1);
        fl(FLASH_WRITE, 4'hd, 32'h0, 1'b0);
        fl(FLASH_READ, 4'h5, 32'h0, 1'b0);
        fl(FLASH_ERASE, 4'h1, 32'h0, 1'b1);
        fl(FLASH_READ, 4'h2, 32'hbff, 1'b1);
        fl(FLASH_READ, 4'h2, 32'hc00, 1'b0);
        fl(FLASH_WRITE, 4'h2, 32'hc00, 1'b1);
        fl(FLASH_WRITE, 4'h2, 32'hbff, 1'b0);
        appCpu.wr_reg(OFS_SECURITY, 32'h0);
        rst(1'b0);
        appCpu.rd_reg(OFS_SECURITY, s);
        chk("sticky", s, 32'h3c);
        appCpu.rd_reg(OFS_EFLASH_BASE, s);
        chk("base kept", s, 32'h0001_2000);
        rst(1'b1);
        appCpu.rd_reg(OFS_SECURITY, s);
        chk("por clear", s, 32'h0);
        appCpu.rd_reg(OFS_EFLASH_BASE, s);
        chk("base por", s, 32'h0);
    endtask : t_secure
    task automatic t_debug();
        logic [31:0] s;
        @(posedge core_clk);
        appSwdIn <= 1'b1;
        radioSwdIn <= 1'b1;
        appCpu.wr_reg(OFS_SYS_CTRL, 32'h8);
        repeat (3) @(posedge core_clk);
        #1 chk("swd allow", 32'(appSwdOut), 32'h1);
        appCpu.wr_reg(OFS_SECURITY, 32'h1);
        #1 chk("swd kill", 32'({appSwdOut, radioSwdOut}), 32'h1);
        appCpu.wr_reg(OFS_SECURITY, 32'h2);
        #1 chk("swd kill radio", 32'({appSwdOut, radioSwdOut}), 32'h0);
        @(posedge core_clk);
        appSwdIn <= 1'b0;
        radioSwdIn <= 1'b0;
        rst(1'b0);
        appCpu.rd_reg(OFS_SYS_CTRL, s);
        chk("allow reset", s, 32'h0);
    endtask : t_debug
    task automatic t_auth(input logic qspi, input logic match, input logic exp);
        @(posedge core_clk);
        authDone <= 1'b1;
        authMatch <= match;
        bootFromQspi <= qspi;
        @(posedge core_clk);
        authDone <= 1'b0;
        #1 chk("boot reset", 32'(hwResetReq), 32'(exp));
    endtask : t_auth
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        powerOnResetn <= 1'b1;
        t_mutex();
        t_regs();
        t_secure();
        t_debug();
        appCpu.wr_reg(OFS_SECURITY, 32'h40);
        t_auth(1'b1, 1'b0, 1'b0);
        t_auth(1'b0, 1'b1, 1'b0);
        t_auth(1'b0, 1'b0, 1'b1);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
